// ---- ppfm_port_mux.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Location bits place timers and serial units.
// - Timer 4 wins shared port 1 pins when the timer priority bit is set, timer 1 is at placement two and timer 4 at placement one.
// - Analog enable bit makes port 0 pin analog.
// - Analog enable register resets to zero.
// - Analog enable overrides port 0 function select.
// - Port 2 pins 1,2 carry debug data/clock.
// - Debug ignores select; drives data when returning.
// - Oscillator select low gives pins 3,4 crystal.
// - In reset all pins inputs with pull-up, except port 2 pins 3,4 while oscillator select is low.
// - Port 0,1 data eight bits, reset 0xff.
// - Port 2 data five bits, reset 0x1f.
// - Port 0,1 function select reset zero.
// - Port 0 priority field orders conflicting peripherals.
// - Timer priority bit resets to timer 1.
module ppfm_port_mux
    import ppfm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire ppfm_sfr_req_t sfr_req,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic [7:0] port0_pin_in,
    input wire logic [7:0] port1_pin_in,
    input wire logic [4:0] port2_pin_in,
    input wire logic [4:0] port2_function_select,
    input wire logic [4:0] port2_direction,
    input wire logic [1:0] port_zero_priority_field,
    input wire logic timer1_vs_timer4_priority,
    input wire logic low_freq_osc_select,
    input wire logic debug_active,
    input wire logic debug_data_out,
    input wire logic debug_data_drive,
    output logic debug_data_in,
    output logic debug_clock_in,
    output logic adc_trigger,
    output logic timer_one_placement,
    output logic timer_three_placement,
    output logic timer_four_placement,
    output logic serial_one_placement,
    output logic serial_zero_placement,
    output logic [1:0] port0_owner_pri,
    output logic port1_timer4_owns,
    output ppfm_pin_ctl_t port0_ctl,
    output ppfm_pin_ctl_t port1_ctl,
    output ppfm_pin_ctl_t port2_ctl,
    output logic [7:0] port0_sync,
    output logic [7:0] port1_sync
);
    logic [7:0] port0_data_r;
    logic [7:0] port1_data_r;
    logic [7:0] port2_data_r;
    logic [7:0] location_r;
    logic [7:0] analog_r;
    logic [7:0] port0_function_select_r;
    logic [7:0] port1_function_select_r;
    logic [7:0] rdata_r;
    logic [4:0] port2_sync;

    // Merges a byte write or a single-bit write into a register.
    function automatic logic [7:0] ppfm_merge(input logic [7:0] cur, input logic byte_wr,
                                              input logic one_bit, input logic [2:0] idx,
                                              input logic v, input logic [7:0] wd,
                                              input logic [7:0] mask);
        logic [7:0] res;
        res = cur;
        if (byte_wr) begin
            res = wd;
        end
        if (one_bit) begin
            res[idx] = v;
        end
        return res & mask;
    endfunction

    // Address decode.
    wire sel_p0 = sfr_req.addr == PPFM_ADDR_PORT0_DATA;
    wire sel_p1 = sfr_req.addr == PPFM_ADDR_PORT1_DATA;
    wire sel_p2 = sfr_req.addr == PPFM_ADDR_PORT2_DATA;
    wire sel_loc = sfr_req.addr == PPFM_ADDR_PERIPHERAL_LOCATION;
    wire sel_adc = sfr_req.addr == PPFM_ADDR_ANALOG_INPUT_ENABLE;
    wire sel_s0 = sfr_req.addr == PPFM_ADDR_PORT0_FUNCTION_SELECT;
    wire sel_s1 = sfr_req.addr == PPFM_ADDR_PORT1_FUNCTION_SELECT;
    wire wr = sfr_req.wr;
    wire bw = bit_wr;
    assign sfr_hit = sel_p0 | sel_p1 | sel_p2 | sel_loc | sel_adc | sel_s0 | sel_s1;

    // Next values; data ports are bit-addressable, port 2 keeps five bits.
    // A byte write and a bit write in one cycle merge with the bit on top, so
    // a read-modify-write from the core never loses the addressed bit.
    // The configuration registers take byte writes only.
    wire [7:0] p0_nxt = ppfm_merge(port0_data_r, wr & sel_p0, bw & sel_p0, bit_sel, bit_val,
                                   sfr_req.wdata, 8'hff);
    wire [7:0] p1_nxt = ppfm_merge(port1_data_r, wr & sel_p1, bw & sel_p1, bit_sel, bit_val,
                                   sfr_req.wdata, 8'hff);
    wire [7:0] p2_nxt = ppfm_merge(port2_data_r, wr & sel_p2, bw & sel_p2, bit_sel, bit_val,
                                   sfr_req.wdata, PPFM_MASK_PORT2);
    wire [7:0] loc_nxt = ppfm_merge(location_r, wr & sel_loc, 1'b0, bit_sel, bit_val,
                                    sfr_req.wdata, PPFM_MASK_LOCATION);
    wire [7:0] adc_nxt = (wr & sel_adc) ? sfr_req.wdata : analog_r;
    wire [7:0] s0_nxt = (wr & sel_s0) ? sfr_req.wdata : port0_function_select_r;
    wire [7:0] s1_nxt = (wr & sel_s1) ? sfr_req.wdata : port1_function_select_r;

    // Read data selection; unmapped addresses read zero.
    wire [7:0] rd_nxt = sel_p0 ? port0_sync :
                        sel_p1 ? port1_sync :
                        sel_p2 ? {3'h0, port2_sync} :
                        sel_loc ? location_r :
                        sel_adc ? analog_r :
                        sel_s0 ? port0_function_select_r :
                        sel_s1 ? port1_function_select_r : PPFM_RST_ZERO;

    // Register bank.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port0_data_r <= PPFM_RST_PORT01_DATA;
            port1_data_r <= PPFM_RST_PORT01_DATA;
            port2_data_r <= PPFM_RST_PORT2_DATA;
            location_r <= PPFM_RST_ZERO;
            analog_r <= PPFM_RST_ZERO;
            port0_function_select_r <= PPFM_RST_ZERO;
            port1_function_select_r <= PPFM_RST_ZERO;
            rdata_r <= PPFM_RST_ZERO;
        end else begin
            port0_data_r <= p0_nxt;
            port1_data_r <= p1_nxt;
            port2_data_r <= p2_nxt;
            location_r <= loc_nxt;
            analog_r <= adc_nxt;
            port0_function_select_r <= s0_nxt;
            port1_function_select_r <= s1_nxt;
            rdata_r <= sfr_req.rd ? rd_nxt : rdata_r;
        end
    end

    assign sfr_rdata = rdata_r;

    // Pin level synchronisers.
    // Each pin passes two flip-flops before any logic here reads it.
    ppfm_sync #(.WIDTH(8)) u_sync0 (
        .clk(clk), .reset_n(reset_n), .async_in(port0_pin_in), .sync_out(port0_sync)
    );
    ppfm_sync #(.WIDTH(8)) u_sync1 (
        .clk(clk), .reset_n(reset_n), .async_in(port1_pin_in), .sync_out(port1_sync)
    );
    ppfm_sync #(.WIDTH(5)) u_sync2 (
        .clk(clk), .reset_n(reset_n), .async_in(port2_pin_in), .sync_out(port2_sync)
    );

    // Placement outputs.
    // A cleared bit keeps placement one, a set bit moves the unit to placement two.
    assign timer_one_placement = location_r[PPFM_BIT_TIMER_ONE];
    assign timer_three_placement = location_r[PPFM_BIT_TIMER_THREE];
    assign timer_four_placement = location_r[PPFM_BIT_TIMER_FOUR];
    assign serial_one_placement = location_r[PPFM_BIT_SERIAL_ONE];
    assign serial_zero_placement = location_r[PPFM_BIT_SERIAL_ZERO];

    // Priority resolution; the priority sources reset to zero outside.
    assign port0_owner_pri = port_zero_priority_field;
    assign port1_timer4_owns = timer1_vs_timer4_priority & !timer_four_placement
                               & timer_one_placement;
    wire [7:0] p1_timer4 = port1_timer4_owns ? PPFM_P1_T4_ALT1_PINS : 8'h00;

    // Port 0: analog wins over function select.
    assign port0_ctl.analog = analog_r;
    assign port0_ctl.periph = port0_function_select_r & ~analog_r;
    assign port0_ctl.pull_up = ~analog_r;
    assign port0_ctl.out_val = port0_data_r;

    // Port 1 has no analog use, so every pin keeps its pull-up.
    // The timer 4 claim adds no pins of its own: a pin becomes a peripheral
    // pin only through its select bit, and the claim decides which unit
    // drives it, as port1_timer4_owns tells the timers.
    assign port1_ctl.analog = 8'h00;
    assign port1_ctl.periph = port1_function_select_r | (port1_function_select_r & p1_timer4);
    assign port1_ctl.pull_up = 8'hff;
    assign port1_ctl.out_val = port1_data_r;

    // Port 2: debug and crystal override register settings.
    // The debug override wins over the select; the crystal override wins over both.
    wire xtal = !low_freq_osc_select;
    logic [7:0] p2_periph;
    logic [7:0] p2_analog;
    always_comb begin
        p2_periph = {3'h0, port2_function_select};
        p2_analog = 8'h00;
        if (debug_active) begin
            p2_periph[PPFM_P2_DEBUG_DATA] = 1'b0;
            p2_periph[PPFM_P2_DEBUG_CLOCK] = 1'b0;
        end
        if (xtal) begin
            p2_periph[PPFM_P2_XTAL_A] = 1'b0;
            p2_periph[PPFM_P2_XTAL_B] = 1'b0;
            p2_analog[PPFM_P2_XTAL_A] = 1'b1;
            p2_analog[PPFM_P2_XTAL_B] = 1'b1;
        end
    end
    assign port2_ctl.periph = p2_periph;
    assign port2_ctl.analog = p2_analog;
    assign port2_ctl.pull_up = ~p2_analog;
    // Debug data pin output is driven by the debug unit only while it returns data.
    assign port2_ctl.out_val = (debug_active & debug_data_drive) ?
        {port2_data_r[7:2], debug_data_out, port2_data_r[0]} : port2_data_r;
    assign debug_data_in = port2_sync[PPFM_P2_DEBUG_DATA];
    assign debug_clock_in = port2_sync[PPFM_P2_DEBUG_CLOCK];
    // Trigger only meaningful as plain input; direction kept by software.
    assign adc_trigger = port2_sync[PPFM_P2_TRIGGER] & !port2_function_select[PPFM_P2_TRIGGER]
                         & !port2_direction[PPFM_P2_TRIGGER];

    // direction registers live outside; at reset all selects and analog
    // bits are zero and pull_up is set, leaving every pin an input with pull-up.
    // If the oscillator select rests low after reset, pins 3 and 4 of port 2
    // go to the crystal at once and lose their pull-ups.
    // Read data of the data ports is the synchronised pin level, so a value
    // written to an output pin shows up two cycles later, never at once.
endmodule

// ---- ppfm_pkg.sv ----
package ppfm_pkg;

    // Special-function register addresses of the port bank.
    localparam logic [7:0] PPFM_ADDR_PORT0_DATA = 8'h80;
    localparam logic [7:0] PPFM_ADDR_PORT1_DATA = 8'h90;
    localparam logic [7:0] PPFM_ADDR_PORT2_DATA = 8'ha0;
    localparam logic [7:0] PPFM_ADDR_PERIPHERAL_LOCATION = 8'hf1;
    localparam logic [7:0] PPFM_ADDR_ANALOG_INPUT_ENABLE = 8'hf2;
    localparam logic [7:0] PPFM_ADDR_PORT0_FUNCTION_SELECT = 8'hf3;
    localparam logic [7:0] PPFM_ADDR_PORT1_FUNCTION_SELECT = 8'hf4;

    // Reset values.
    localparam logic [7:0] PPFM_RST_PORT01_DATA = 8'hff;
    localparam logic [7:0] PPFM_RST_PORT2_DATA = 8'h1f;
    localparam logic [7:0] PPFM_RST_ZERO = 8'h00;

    // Writable bit masks.
    localparam logic [7:0] PPFM_MASK_PORT2 = 8'h1f;
    localparam logic [7:0] PPFM_MASK_LOCATION = 8'h73;

    // Field positions in the peripheral location register.
    localparam int PPFM_BIT_TIMER_ONE = 6;
    localparam int PPFM_BIT_TIMER_THREE = 5;
    localparam int PPFM_BIT_TIMER_FOUR = 4;
    localparam int PPFM_BIT_SERIAL_ONE = 1;
    localparam int PPFM_BIT_SERIAL_ZERO = 0;

    // Port 2 pin positions.
    localparam int PPFM_P2_TRIGGER = 0;
    localparam int PPFM_P2_DEBUG_DATA = 1;
    localparam int PPFM_P2_DEBUG_CLOCK = 2;
    localparam int PPFM_P2_XTAL_A = 3;
    localparam int PPFM_P2_XTAL_B = 4;

    // Port 1 pins shared by timer 1 placement two and timer 4 placement one.
    localparam logic [7:0] PPFM_P1_T4_ALT1_PINS = 8'h03;

    // Port 0 priority field encodings.
    typedef enum logic [1:0] {
        PPFM_PRI_SERIAL_ZERO = 2'h0,
        PPFM_PRI_SERIAL_ONE = 2'h1,
        PPFM_PRI_TIMER1_CH01 = 2'h2,
        PPFM_PRI_TIMER1_CH2 = 2'h3
    } ppfm_p0_pri_t;

    // Register bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppfm_sfr_req_t;

    // Per-port pin control carried to the pads.
    typedef struct packed {
        logic [7:0] periph;
        logic [7:0] analog;
        logic [7:0] pull_up;
        logic [7:0] out_val;
    } ppfm_pin_ctl_t;

endpackage

// ---- ppfm_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels.
module ppfm_sync
    import ppfm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// ---- ppfm_pad_model.sv ----
`timescale 1ns/1ps
// Board side of one port: a driven pin shows the board level, a released one
// falls to its pull-up or else drifts away from the last driven level.
module ppfm_pad_model #(
    parameter int W = 8
) (
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] pull_up,
    output logic [W-1:0] pin
);
    // Resolve each pin from the board driver first, then the pull-up.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = ext_en[i] ? ext_val[i] : (pull_up[i] ? 1'b1 : ~ext_val[i]);
        end
    end
endmodule

// ---- ppfm_port_mux_properties.sv ----
`timescale 1ns/1ps
// Port bank checks, all on the system clock.
module ppfm_port_mux_properties
    import ppfm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire ppfm_sfr_req_t sfr_req,
    input wire logic bit_wr,
    input wire logic [7:0] sfr_rdata,
    input wire logic [1:0] port_zero_priority_field,
    input wire logic timer1_vs_timer4_priority,
    input wire logic low_freq_osc_select,
    input wire logic debug_active,
    input wire logic timer_one_placement,
    input wire logic timer_three_placement,
    input wire logic timer_four_placement,
    input wire logic serial_one_placement,
    input wire logic serial_zero_placement,
    input wire logic [1:0] port0_owner_pri,
    input wire logic port1_timer4_owns,
    input wire ppfm_pin_ctl_t port0_ctl,
    input wire ppfm_pin_ctl_t port2_ctl
);
    logic [7:0] wd_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Keeps the last write data so placement bits can be compared field by field.
    always_ff @(posedge clk) begin
        wd_q <= sfr_req.wdata;
    end
    a_analog_write: assert property (sfr_req.wr && !bit_wr && sfr_req.addr == 8'hf2
        |=> port0_ctl.analog == $past(sfr_req.wdata)) else $error("analog enable not applied");
    a_analog_wins: assert property ((port0_ctl.analog & port0_ctl.periph) == 8'h00)
        else $error("analog pin also peripheral");
    a_timer4_wins: assert property (port1_timer4_owns == (timer1_vs_timer4_priority
        && timer_one_placement && !timer_four_placement)) else $error("port 1 owner wrong");
    a_location_write: assert property (sfr_req.wr && !bit_wr && sfr_req.addr == 8'hf1 |=>
        {timer_one_placement, timer_three_placement, timer_four_placement, serial_one_placement,
        serial_zero_placement} == {wd_q[6:4], wd_q[1:0]}) else $error("placement bits wrong");
    a_location_unused: assert property (sfr_req.rd && sfr_req.addr == 8'hf1
        |=> (sfr_rdata & 8'h8c) == 8'h00) else $error("unused location bits set");
    a_port2_upper: assert property (sfr_req.rd && sfr_req.addr == 8'ha0
        |=> sfr_rdata[7:5] == 3'h0) else $error("port 2 upper bits set");
    a_debug_select: assert property (debug_active |-> port2_ctl.periph[2:1] == 2'h0)
        else $error("debug pins still peripheral");
    a_crystal_pins: assert property (!low_freq_osc_select |-> port2_ctl.analog[4:3] == 2'h3)
        else $error("crystal pins not analog");
    a_priority_copy: assert property (port0_owner_pri == port_zero_priority_field)
        else $error("port 0 priority wrong");
endmodule

// ---- test_port_pin_function_mux.sv ----
`timescale 1ns/1ps
module test_port_pin_function_mux
    import ppfm_pkg::*;
;
    logic clk, reset_n, bit_wr, bit_val, timer1_vs_timer4_priority, low_freq_osc_select, sfr_hit;
    logic debug_active, debug_data_out, debug_data_drive, debug_data_in, debug_clock_in, adc_trigger;
    logic timer_one_placement, timer_three_placement, timer_four_placement, port1_timer4_owns;
    logic serial_one_placement, serial_zero_placement;
    logic [2:0] bit_sel;
    logic [1:0] port_zero_priority_field, port0_owner_pri;
    logic [4:0] port2_pin_in, port2_function_select, port2_direction, p2_ext;
    logic [7:0] sfr_rdata, port0_pin_in, port1_pin_in, port0_sync, port1_sync, p0_ext, p1_ext;
    ppfm_sfr_req_t sfr_req;
    ppfm_pin_ctl_t port0_ctl, port1_ctl, port2_ctl;
    logic [7:0] p0_en, p1_en;
    logic [4:0] p2_en;
    wire [4:0] placements = {timer_one_placement, timer_three_placement, timer_four_placement,
                             serial_one_placement, serial_zero_placement};
    int fails, samples_checked;
    ppfm_port_mux i_dut (.*);
    ppfm_pad_model #(.W(8)) i_pad0 (.ext_val(p0_ext), .ext_en(p0_en),
        .pull_up(port0_ctl.pull_up), .pin(port0_pin_in));
    ppfm_pad_model #(.W(8)) i_pad1 (.ext_val(p1_ext), .ext_en(p1_en),
        .pull_up(port1_ctl.pull_up), .pin(port1_pin_in));
    ppfm_pad_model #(.W(5)) i_pad2 (.ext_val(p2_ext), .ext_en(p2_en),
        .pull_up(port2_ctl.pull_up[4:0]), .pin(port2_pin_in));
    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req.wr <= 1'b1;
        sfr_req.addr <= a;
        sfr_req.wdata <= d;
        @(posedge clk);
        sfr_req.wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(posedge clk);
        bit_wr <= 1'b1;
        sfr_req.addr <= a;
        bit_sel <= s;
        bit_val <= v;
        @(posedge clk);
        bit_wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_req.rd <= 1'b1;
        sfr_req.addr <= a;
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        @(negedge clk);
        chk(sfr_rdata, exp);
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Cuts a hang short; the sequence needs well under 300 cycles.
    initial begin
        #20000;
        fails++;
        results();
    end
    // Main sequence of register and pin scenarios.
    initial begin
        fails = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        sfr_req = '0;
        {bit_wr, bit_sel, bit_val, debug_active, debug_data_out, debug_data_drive} = '0;
        {port2_function_select, port2_direction, port_zero_priority_field} = '0;
        timer1_vs_timer4_priority = 1'b0;
        low_freq_osc_select = 1'b1;
        p0_ext = 8'h3c;
        p1_ext = 8'hc3;
        p2_ext = 5'h15;
        p0_en = 8'hff;
        p1_en = 8'hff;
        p2_en = 5'h1f;
        repeat (6) @(posedge clk);
        chk(port0_ctl.pull_up & port1_ctl.pull_up, 8'hff);
        chk(port0_ctl.periph | port0_ctl.analog, 8'h00);
        reset_n <= 1'b1;
        rchk(PPFM_ADDR_ANALOG_INPUT_ENABLE, 8'h00);
        rchk(PPFM_ADDR_PERIPHERAL_LOCATION, 8'h00);
        rchk(PPFM_ADDR_PORT0_FUNCTION_SELECT, 8'h00);
        rchk(PPFM_ADDR_PORT1_FUNCTION_SELECT, 8'h00);
        chk(port1_ctl.out_val, 8'hff);
        chk({3'h0, port2_ctl.out_val[4:0]}, 8'h1f);
        chk({7'h0, port1_timer4_owns}, 8'h00);
        $display("test reset state done");
        rchk(PPFM_ADDR_PORT0_DATA, 8'h3c);
        rchk(PPFM_ADDR_PORT1_DATA, 8'hc3);
        rchk(PPFM_ADDR_PORT2_DATA, 8'h15);
        chk({7'h0, sfr_hit}, 8'h01);
        chk(port0_sync, 8'h3c);
        rchk(8'hf0, 8'h00);
        chk({7'h0, sfr_hit}, 8'h00);
        wr(PPFM_ADDR_PORT0_DATA, 8'h5a);
        chk(port0_ctl.out_val, 8'h5a);
        bw(PPFM_ADDR_PORT1_DATA, 3'h3, 1'b0);
        chk(port1_ctl.out_val, 8'hf7);
        // Board lets go of the upper port 1 pins; their pull-ups must hold them high.
        @(posedge clk);
        p1_en <= 8'h0f;
        repeat (3) @(posedge clk);
        rchk(PPFM_ADDR_PORT1_DATA, 8'hf3);
        chk(port1_sync, 8'hf3);
        $display("test data ports done");
        wr(PPFM_ADDR_PERIPHERAL_LOCATION, 8'hff);
        rchk(PPFM_ADDR_PERIPHERAL_LOCATION, 8'h73);
        chk({3'h0, placements}, 8'h1f);
        wr(PPFM_ADDR_PERIPHERAL_LOCATION, 8'h40);
        chk({3'h0, placements}, 8'h10);
        @(posedge clk);
        timer1_vs_timer4_priority <= 1'b1;
        @(negedge clk);
        chk({7'h0, port1_timer4_owns}, 8'h01);
        @(posedge clk);
        timer1_vs_timer4_priority <= 1'b0;
        @(negedge clk);
        chk({7'h0, port1_timer4_owns}, 8'h00);
        $display("test placement done");
        wr(PPFM_ADDR_PORT0_FUNCTION_SELECT, 8'hff);
        wr(PPFM_ADDR_ANALOG_INPUT_ENABLE, 8'h0f);
        chk(port0_ctl.analog, 8'h0f);
        chk(port0_ctl.periph, 8'hf0);
        wr(PPFM_ADDR_PORT1_FUNCTION_SELECT, 8'ha5);
        rchk(PPFM_ADDR_PORT1_FUNCTION_SELECT, 8'ha5);
        chk(port1_ctl.periph, 8'ha5);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            port_zero_priority_field <= i[1:0];
            @(negedge clk);
            chk({6'h0, port0_owner_pri}, {6'h0, i[1:0]});
        end
        $display("test analog and priority done");
        @(posedge clk);
        debug_active <= 1'b1;
        port2_function_select <= 5'h1e;
        port2_direction <= 5'h00;
        debug_data_drive <= 1'b1;
        low_freq_osc_select <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            p2_ext <= k[0] ? 5'h0a : 5'h15;
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk({5'h0, adc_trigger, debug_clock_in, debug_data_in}, k[0] ? 8'h01 : 8'h06);
        end
        chk({6'h0, port2_ctl.periph[2:1]}, 8'h00);
        chk({7'h0, port2_ctl.out_val[1]}, 8'h00);
        chk({6'h0, port2_ctl.analog[4:3]}, 8'h03);
        chk({6'h0, port2_ctl.periph[4:3]}, 8'h00);
        @(posedge clk);
        debug_data_drive <= 1'b0;
        @(negedge clk);
        chk({7'h0, port2_ctl.out_val[1]}, 8'h01);
        @(posedge clk);
        debug_active <= 1'b0;
        low_freq_osc_select <= 1'b1;
        @(negedge clk);
        chk({3'h0, port2_ctl.periph[4:0]}, 8'h1e);
        chk({3'h0, port2_ctl.pull_up[4:0]}, 8'h1f);
        $display("test debug and crystal done");
        results();
    end
endmodule
bind ppfm_port_mux ppfm_port_mux_properties i_props (.*);
